// ===== hasb_consts.svh
// Constants for the handler active status register bank.
`ifndef HASB_CONSTS_SVH
`define HASB_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define HASB_REG_OFFSET     12'hd24
`define HASB_RESET_VAL      32'h00000000
`define HASB_RW_MASK        32'h0000058b
`define HASB_RSVD_MASK      32'h00000274
`define HASB_UPPER_MASK     32'hfffff800

// ----------------------------------------------------------------------
// Field positions within the register word
// ----------------------------------------------------------------------
`define HASB_BIT_PEND_ACT   10
`define HASB_BIT_DBG_LIVE   8
`define HASB_BIT_SVC_ACT    7
`define HASB_BIT_USG_ACT    3
`define HASB_BIT_BUS_ACT    1
`define HASB_BIT_MEM_ACT    0

// ----------------------------------------------------------------------
// Positions within the internal six-flag vector
// ----------------------------------------------------------------------
`define HASB_IDX_MEM        0
`define HASB_IDX_BUS        1
`define HASB_IDX_USG        2
`define HASB_IDX_SVC        3
`define HASB_IDX_DBG        4
`define HASB_IDX_PEND       5
`define HASB_NUM_FLAGS      6

// ----------------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------------
`define HASB_HSIZE_WORD     3'h2
`define HASB_HTRANS_ACT_BIT 1
`define HASB_HPROT_PRIV_BIT 1
`define HASB_HRESP_OKAY     1'h0
`define HASB_HREADY_ALWAYS  1'h1
`define HASB_FLAG_RESET     1'h0

`endif

// ===== hasb_pkg.sv
// Types shared by the handler active status register bank.
package hasb_pkg;

  // ----------------------------------------------------------------------
  // Data phase kinds
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_READ,
    PH_WRITE,
    PH_IGNORE
  } hasb_phase_e;

  typedef logic [5:0]  hasb_flags_t;
  typedef logic [31:0] hasb_word_t;

endpackage

// ===== hasb_active_flag.sv
// One active flag with software write and exception controller set/clear.
`timescale 1ns/100ps
`include "hasb_consts.svh"

module hasb_active_flag (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic swWrite,
  input  wire logic swValue,
  input  wire logic hwSet,
  input  wire logic hwClear,
  output logic      flagD,
  output logic      flagQ
);

  logic flag_q;
  logic flag_d;

  // ----------------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------------
  // Exception entry beats return, and both beat software, so that an
  // entry landing in the same cycle as a software clear is not lost.
  always_comb begin
    flag_d = flag_q;
    if (swWrite) begin
      flag_d = swValue;
    end
    if (hwClear) begin
      flag_d = 1'b0;
    end
    if (hwSet) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flag_q <= `HASB_FLAG_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flagD = flag_d;
  assign flagQ = flag_q;

endmodule

// ===== hasb_regbank.sv
// AHB-Lite register bank holding the system handler active flags.
// Function
// - Bit 10 reads the pendable service call active state.
// - Writing bit 10 sets the pendable service call active state.
// - Bit 8 is read-write and shows the debug monitor active state.
// - Bit 7 reads the supervisor call active state.
// - Writing bit 7 sets the supervisor call active state.
// - Bit 3 reads the usage fault active state.
// - Writing bit 3 sets the usage fault active state.
// - Bit 1 reads the bus fault active state.
// - Writing bit 1 sets the bus fault active state.
// - Bit 0 reads the memory management fault active state.
// - Writing bit 0 sets the memory management fault active state.
// - Bits 9, 6:4 and 2 are read-only and reset to zero.
// - The register is reachable only from privileged accesses.
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`include "hasb_consts.svh"

module hasb_regbank (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [3:0]  hprot,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [5:0]  exceptionEntry,
  input  wire logic [5:0]  exceptionReturn,
  output logic             pendableServiceActive,
  output logic             debuggerHandlerLive,
  output logic             supervisorCallActive,
  output logic             usageFaultActive,
  output logic             busFaultActive,
  output logic             memoryManageFaultActive
);

  // ----------------------------------------------------------------------
  // Field packing
  // ----------------------------------------------------------------------
  // Reserved and out-of-scope positions are left at zero by construction.
  function automatic hasb_pkg::hasb_word_t packWord(
    input hasb_pkg::hasb_flags_t flags
  );
    hasb_pkg::hasb_word_t w;
    w = `HASB_RESET_VAL;
    w[`HASB_BIT_PEND_ACT]  = flags[`HASB_IDX_PEND];
    w[`HASB_BIT_DBG_LIVE]  = flags[`HASB_IDX_DBG];
    w[`HASB_BIT_SVC_ACT]   = flags[`HASB_IDX_SVC];
    w[`HASB_BIT_USG_ACT]   = flags[`HASB_IDX_USG];
    w[`HASB_BIT_BUS_ACT]   = flags[`HASB_IDX_BUS];
    w[`HASB_BIT_MEM_ACT]   = flags[`HASB_IDX_MEM];
    return w;
  endfunction

  function automatic hasb_pkg::hasb_flags_t unpackWord(
    input hasb_pkg::hasb_word_t w
  );
    hasb_pkg::hasb_flags_t f;
    f = '0;
    f[`HASB_IDX_PEND]  = w[`HASB_BIT_PEND_ACT];
    f[`HASB_IDX_DBG]   = w[`HASB_BIT_DBG_LIVE];
    f[`HASB_IDX_SVC]   = w[`HASB_BIT_SVC_ACT];
    f[`HASB_IDX_USG]   = w[`HASB_BIT_USG_ACT];
    f[`HASB_IDX_BUS]   = w[`HASB_BIT_BUS_ACT];
    f[`HASB_IDX_MEM]   = w[`HASB_BIT_MEM_ACT];
    return f;
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  hasb_pkg::hasb_phase_e phase_q;
  hasb_pkg::hasb_phase_e phase_d;
  hasb_pkg::hasb_word_t  rdata_q;
  hasb_pkg::hasb_word_t  rdata_d;
  hasb_pkg::hasb_flags_t flagD;
  hasb_pkg::hasb_flags_t flagQ;
  hasb_pkg::hasb_flags_t swValue;
  logic                  accept;
  logic                  addrHit;
  logic                  privileged;
  logic                  wordSize;
  logic                  swWrite;

  // ----------------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------------
  // Only address bits 11:2 are decoded, so the register
  // aliases every 4 KB of the address space.
  assign accept     = hsel && hready && htrans[`HASB_HTRANS_ACT_BIT];
  assign addrHit    = ({haddr[11:2], 2'h0} == `HASB_REG_OFFSET);
  assign privileged = hprot[`HASB_HPROT_PRIV_BIT];
  assign wordSize   = (hsize == `HASB_HSIZE_WORD);

  // Read data is built from the flags' next value, so a read whose address
  // phase overlaps the data phase of a write already sees that write.
  always_comb begin
    phase_d = hasb_pkg::PH_IDLE;
    rdata_d = rdata_q;
    if (accept) begin
      if (hwrite) begin
        if (addrHit && privileged && wordSize) begin
          phase_d = hasb_pkg::PH_WRITE;
        end else begin
          phase_d = hasb_pkg::PH_IGNORE;
        end
      end else begin
        phase_d = hasb_pkg::PH_READ;
        if (addrHit && privileged) begin
          rdata_d = packWord(flagD);
        end else begin
          rdata_d = `HASB_RESET_VAL;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase_q <= hasb_pkg::PH_IDLE;
      rdata_q <= `HASB_RESET_VAL;
    end else begin
      phase_q <= phase_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Flag storage
  // ----------------------------------------------------------------------
  // Only the six defined positions are unpacked; the reserved positions
  // of hwdata have nowhere to go.
  assign swWrite = (phase_q == hasb_pkg::PH_WRITE);
  assign swValue = unpackWord(hwdata);

  genvar gi;
  generate
    for (gi = 0; gi < `HASB_NUM_FLAGS; gi = gi + 1) begin : g_flag
      hasb_active_flag u_flag (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .swWrite  (swWrite),
        .swValue  (swValue[gi]),
        .hwSet    (exceptionEntry[gi]),
        .hwClear  (exceptionReturn[gi]),
        .flagD    (flagD[gi]),
        .flagQ    (flagQ[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hreadyout               = `HASB_HREADY_ALWAYS;
  assign hresp                   = `HASB_HRESP_OKAY;
  assign hrdata                  = rdata_q;
  assign pendableServiceActive   = flagQ[`HASB_IDX_PEND];
  assign debuggerHandlerLive     = flagQ[`HASB_IDX_DBG];
  assign supervisorCallActive    = flagQ[`HASB_IDX_SVC];
  assign usageFaultActive        = flagQ[`HASB_IDX_USG];
  assign busFaultActive          = flagQ[`HASB_IDX_BUS];
  assign memoryManageFaultActive = flagQ[`HASB_IDX_MEM];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic privRead;
  logic quietHw;
  assign quietHw = (exceptionEntry == '0) && (exceptionReturn == '0);
  assign privRead = accept && !hwrite && addrHit && privileged;

  sequence privReadSeq;
    privRead ##1 (phase_q == hasb_pkg::PH_READ);
  endsequence

  sequence swWriteSeq;
    swWrite && quietHw;
  endsequence

  AST_RD_PEND: assert property (
    privReadSeq |-> hrdata[`HASB_BIT_PEND_ACT] == pendableServiceActive)
    else $error("pendable service active bit reads wrong");

  AST_RD_DBG: assert property (
    privReadSeq |-> hrdata[`HASB_BIT_DBG_LIVE] == debuggerHandlerLive)
    else $error("debug monitor active bit reads wrong");

  AST_RD_SVC: assert property (
    privReadSeq |-> hrdata[`HASB_BIT_SVC_ACT] == supervisorCallActive)
    else $error("supervisor call active bit reads wrong");

  AST_RD_USG: assert property (
    privReadSeq |-> hrdata[`HASB_BIT_USG_ACT] == usageFaultActive)
    else $error("usage fault active bit reads wrong");

  AST_RD_BUS: assert property (
    privReadSeq |-> hrdata[`HASB_BIT_BUS_ACT] == busFaultActive)
    else $error("bus fault active bit reads wrong");

  AST_RD_MEM: assert property (
    privReadSeq |-> hrdata[`HASB_BIT_MEM_ACT] == memoryManageFaultActive)
    else $error("memory manage fault active bit reads wrong");

  AST_WR_PEND: assert property (
    swWriteSeq |=> pendableServiceActive == $past(hwdata[`HASB_BIT_PEND_ACT]))
    else $error("write to pendable service active bit not taken");

  AST_WR_DBG: assert property (
    swWriteSeq |=> debuggerHandlerLive == $past(hwdata[`HASB_BIT_DBG_LIVE]))
    else $error("write to debug monitor active bit not taken");

  AST_WR_SVC: assert property (
    swWriteSeq |=> supervisorCallActive == $past(hwdata[`HASB_BIT_SVC_ACT]))
    else $error("write to supervisor call active bit not taken");

  AST_WR_USG: assert property (
    swWriteSeq |=> usageFaultActive == $past(hwdata[`HASB_BIT_USG_ACT]))
    else $error("write to usage fault active bit not taken");

  AST_WR_BUS: assert property (
    swWriteSeq |=> busFaultActive == $past(hwdata[`HASB_BIT_BUS_ACT]))
    else $error("write to bus fault active bit not taken");

  AST_WR_MEM: assert property (
    swWriteSeq |=> memoryManageFaultActive == $past(hwdata[`HASB_BIT_MEM_ACT]))
    else $error("write to memory manage fault active bit not taken");

  AST_RSVD_ZERO: assert property (
    (phase_q == hasb_pkg::PH_READ)
      |-> (hrdata & (`HASB_RSVD_MASK | `HASB_UPPER_MASK)) == '0)
    else $error("reserved bits read nonzero");

  AST_RSVD_IGNORED: assert property (
    (swWrite && quietHw && (hwdata & `HASB_RSVD_MASK) != '0)
      ##[1:8] privRead |=> (hrdata & `HASB_RSVD_MASK) == '0)
    else $error("reserved bits took a written value");

  AST_UNPRIV_WRITE: assert property (
    (accept && hwrite && !privileged) ##1 quietHw |=> $stable(flagQ))
    else $error("unprivileged write changed a flag");

  AST_UNPRIV_READ: assert property (
    (accept && !hwrite && !privileged) |=> hrdata == '0)
    else $error("unprivileged read returned data");

  AST_ENTRY_WINS: assert property (
    (swWrite && (exceptionEntry != '0))
      |=> (flagQ & $past(exceptionEntry)) == $past(exceptionEntry))
    else $error("exception entry lost against a software write");

  // ----------------------------------------------------------------------
  // Exception controller and storage
  // ----------------------------------------------------------------------
  // A return that meets an entry of the same flag loses, so only returns
  // that stand alone are expected to clear their flag.
  hasb_pkg::hasb_flags_t retOnly;
  assign retOnly = exceptionReturn & ~exceptionEntry;

  sequence entrySeq;
    exceptionEntry != '0;
  endsequence

  sequence returnSeq;
    retOnly != '0;
  endsequence

  AST_ENTRY_SETS: assert property (
    entrySeq |=> (flagQ & $past(exceptionEntry)) == $past(exceptionEntry))
    else $error("exception entry did not set its flag");

  AST_RETURN_CLEARS: assert property (
    returnSeq |=> (flagQ & $past(retOnly)) == '0)
    else $error("exception return did not clear its flag");

  AST_FLAGS_HOLD: assert property (
    (!swWrite && quietHw) |=> $stable(flagQ))
    else $error("a flag changed with no write and no exception event");

  // The default disable is switched off here, since it would hide exactly
  // the cycles in which reset must clear the state.
  AST_RESET_CLEAR: assert property (
    disable iff (1'b0) !rst_n |=> (flagQ == '0) && (hrdata == '0))
    else $error("reset left a flag or the read data set");

endmodule

// ===== handler_active_status_bits_tb_top.sv
// Self-checking testbench for the handler active status register bank.
`timescale 1ns/100ps

module handler_active_status_bits_tb_top;

  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  localparam logic [31:0] RegAddr = 32'h00000d24;
  localparam logic [3:0]  PrivOn  = 4'h3;
  localparam logic [3:0]  PrivOff = 4'h1;
  localparam int          BitPos [6] = '{0, 1, 3, 7, 8, 10};

  logic        core_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [3:0]  hprot;
  logic [31:0] hwdata;
  wire logic   hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [5:0]  exceptionEntry;
  logic [5:0]  exceptionReturn;
  wire [5:0]   flagsSeen;
  logic [31:0] rd;
  int          nErrors;
  int          numChecks;

  `define CHECK(what, exp, got) begin \
    numChecks++; \
    if ((got) !== (exp)) begin \
      nErrors++; \
      $display("ERROR %s expected %h seen %h", what, exp, got); \
    end \
  end

  // A single slave drives the bus ready line.
  assign hready = hreadyout;

  hasb_regbank i_hasb_regbank (
    .core_clk                (core_clk),
    .rst_n                   (rst_n),
    .hsel                    (hsel),
    .haddr                   (haddr),
    .htrans                  (htrans),
    .hwrite                  (hwrite),
    .hsize                   (hsize),
    .hprot                   (hprot),
    .hwdata                  (hwdata),
    .hready                  (hready),
    .hreadyout               (hreadyout),
    .hresp                   (hresp),
    .hrdata                  (hrdata),
    .exceptionEntry          (exceptionEntry),
    .exceptionReturn         (exceptionReturn),
    .pendableServiceActive   (flagsSeen[5]),
    .debuggerHandlerLive     (flagsSeen[4]),
    .supervisorCallActive    (flagsSeen[3]),
    .usageFaultActive        (flagsSeen[2]),
    .busFaultActive          (flagsSeen[1]),
    .memoryManageFaultActive (flagsSeen[0])
  );

  always #5 core_clk = ~core_clk;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] toWord(input logic [5:0] f);
    logic [31:0] w;
    w = 32'h00000000;
    for (int i = 0; i < 6; i++) begin
      w[BitPos[i]] = f[i];
    end
    return w;
  endfunction

  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'h1 && n < 50);
    if (n >= 50) begin
      nErrors++;
      $display("ERROR hready expected 1 seen stuck low");
    end
  endtask

  task automatic busXfer(input logic wr, input logic [31:0] addr,
                         input logic [31:0] wdata, input logic [3:0] prot,
                         output logic [31:0] rdata);
    @(posedge core_clk);
    hsel   <= 1'h1;
    haddr  <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    hprot  <= prot;
    waitReady();
    htrans <= 2'h0;
    hwdata <= wdata;
    waitReady();
    rdata = hrdata;
    `CHECK("hresp", 1'h0, hresp)
  endtask

  // Waits for a write to land, then checks outputs and the read-back word.
  task automatic checkState(input logic [5:0] expFlags);
    @(posedge core_clk);
    #1;
    `CHECK("flags", expFlags, flagsSeen)
    busXfer(1'h0, RegAddr, 32'h0, PrivOn, rd);
    `CHECK("word", toWord(expFlags), rd)
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic testEachBit();
    for (int i = 0; i < 6; i++) begin
      // Reserved bits are set as well; they must be dropped.
      busXfer(1'h1, RegAddr, toWord(6'h1 << i) | 32'h00000274, PrivOn, rd);
      checkState(6'h1 << i);
      busXfer(1'h1, RegAddr, 32'h00000000, PrivOn, rd);
      checkState(6'h00);
    end
  endtask

  task automatic testAllAndPrivilege();
    busXfer(1'h1, RegAddr, 32'hffffffff, PrivOn, rd);
    checkState(6'h3f);
    busXfer(1'h1, RegAddr, 32'h00000000, PrivOff, rd);
    checkState(6'h3f);
    busXfer(1'h0, RegAddr, 32'h0, PrivOff, rd);
    `CHECK("unprivileged read", 32'h00000000, rd)
    busXfer(1'h1, RegAddr, 32'h00000000, PrivOn, rd);
    checkState(6'h00);
  endtask

  task automatic testHardware();
    @(posedge core_clk);
    exceptionEntry <= 6'h2a;
    @(posedge core_clk);
    exceptionEntry <= 6'h00;
    checkState(6'h2a);
    @(posedge core_clk);
    exceptionReturn <= 6'h0a;
    @(posedge core_clk);
    exceptionReturn <= 6'h00;
    checkState(6'h20);
  endtask

  // An entry and a return that meet a software write in its data phase
  // both take priority over the written value.
  task automatic testCollision();
    fork
      busXfer(1'h1, RegAddr, toWord(6'h08), PrivOn, rd);
      begin
        repeat (2) @(posedge core_clk);
        exceptionEntry  <= 6'h04;
        exceptionReturn <= 6'h08;
        @(posedge core_clk);
        exceptionEntry  <= 6'h00;
        exceptionReturn <= 6'h00;
      end
    join
    checkState(6'h04);
  endtask

  // Saves the live status, sets one flag by read-modify-write, restores.
  task automatic testReadModifyWrite();
    logic [31:0] saved;
    busXfer(1'h0, RegAddr, 32'h0, PrivOn, saved);
    `CHECK("saved", toWord(6'h04), saved)
    busXfer(1'h1, RegAddr, saved | 32'h00000080, PrivOn, rd);
    checkState(6'h0c);
    busXfer(1'h1, RegAddr, saved, PrivOn, rd);
    checkState(6'h04);
  endtask

  task automatic testMidReset();
    busXfer(1'h1, RegAddr, 32'h0000058b, PrivOn, rd);
    checkState(6'h3f);
    @(posedge core_clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    checkState(6'h00);
  endtask

  // ---------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------
  task automatic reportAndStop();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles.
  initial begin
    #100000;
    nErrors++;
    reportAndStop();
  end

  initial begin
    core_clk        = 1'h0;
    rst_n           = 1'h0;
    hsel            = 1'h0;
    haddr           = 32'h0;
    htrans          = 2'h0;
    hwrite          = 1'h0;
    hsize           = 3'h2;
    hprot           = PrivOn;
    hwdata          = 32'h0;
    exceptionEntry  = 6'h00;
    exceptionReturn = 6'h00;
    nErrors         = 0;
    numChecks       = 0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'h1;
    checkState(6'h00);
    testEachBit();
    testAllAndPrivilege();
    testHardware();
    testCollision();
    testReadModifyWrite();
    testMidReset();
    reportAndStop();
  end

endmodule
